// ===== logic/fsr_pkg.sv
// fsr_pkg: constants for the fault flag and command register block.
// assumes a 40 MHz logic clock and 32-bit spi frames, msb first.
package fsr_pkg;
  // ==========================================================
  // frame layout
  localparam int          FRAME_BITS  = 32;
  localparam int          RW_BIT      = 24;
  localparam int          BIT_SUMMARY = 23;
  localparam int          BIT_INTFLG  = 22;
  // ==========================================================
  // command addresses and response headers
  localparam logic [6:0]  ADDR_SWITCH = 7'h1F;
  localparam logic [6:0]  ADDR_FAULT  = 7'h21;
  localparam logic [6:0]  ADDR_IRQ    = 7'h23;
  localparam logic [6:0]  ADDR_RESET  = 7'h24;
  localparam logic [6:0]  ADDR_LAST   = 7'h24;
  localparam logic [7:0]  HDR_FAULT   = 8'h42;
  localparam logic [7:0]  HDR_IRQ     = 8'h47;
  localparam logic [7:0]  HDR_SWITCH  = 8'h3E;
  // ==========================================================
  // fault flag positions, equal to response bit positions
  localparam int          FLAG_W      = 11;
  localparam int          F_SPI_ERR   = 10;
  localparam int          F_HASH      = 9;
  localparam int          F_SUP_LOW   = 7;
  localparam int          F_SUP_HIGH  = 6;
  localparam int          F_TW        = 5;
  localparam int          F_TL        = 4;
  localparam int          F_INT_WAKE  = 3;
  localparam int          F_PIN_WAKE  = 2;
  localparam int          F_SPI_WAKE  = 1;
  localparam int          F_POR       = 0;
  localparam logic [10:0] FLAGS_RESET = 11'h001;
  localparam logic        INTFLG_RST  = 1'b1;
  localparam int          SW_W        = 22;
  // ==========================================================
  // timing
  localparam int          CLK_KHZ      = 40000;
  localparam int          INT_PULSE_US = 100;
  localparam int          INT_PULSE_CYC = INT_PULSE_US * CLK_KHZ / 1000;
  localparam int          PCNT_W       = 12;
  // ==========================================================
  // response selected for the next frame
  typedef enum logic [1:0] {
    RESP_SWITCH = 2'b00,
    RESP_FAULT  = 2'b01,
    RESP_IRQ    = 2'b10
  } fsr_resp_t;
endpackage

// ===== logic/fsr_spi_target.sv
// fsr_spi_target: spi target shifter, oversampled by mclk.
// assumes sclk idles low, mosi sampled on rise, miso changes on fall.
`timescale 1ns/1ps
module fsr_spi_target
  import fsr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic             miso,
  output logic             miso_oe,
  input  wire logic [31:0] tx_word,
  output logic             frame_start,
  output logic             frame_done,
  output logic             frame_err,
  output logic [31:0]      rx_word
);
  // ==========================================================
  // three-stage sync; second and third must agree
  logic [2:0]  sync_reg [3];
  logic [2:0]  lvl_reg, lvl_next;
  logic [31:0] tx_reg, tx_next, rx_reg, rx_next;
  logic [5:0]  cnt_reg, cnt_next;
  logic        sck_rise, sck_fall, cs_fall, cs_rise, act;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      lvl_next[i] = (sync_reg[i][1] == sync_reg[i][2]) ? sync_reg[i][2] : lvl_reg[i];
    end
  end

  assign sck_rise = lvl_next[0] & ~lvl_reg[0];
  assign sck_fall = ~lvl_next[0] & lvl_reg[0];
  assign cs_fall  = ~lvl_next[1] & lvl_reg[1];
  assign cs_rise  = lvl_next[1] & ~lvl_reg[1];
  assign act      = ~lvl_reg[1];

  // ==========================================================
  // shift engine
  always_comb begin
    tx_next  = tx_reg;
    rx_next  = rx_reg;
    cnt_next = cnt_reg;
    if (cs_fall) begin
      tx_next  = tx_word;
      cnt_next = 6'h00;
    end else if (act && sck_rise) begin
      rx_next  = {rx_reg[30:0], lvl_reg[2]};
      cnt_next = (cnt_reg == 6'h3F) ? cnt_reg : cnt_reg + 6'h01;
    end else if (act && sck_fall) begin
      tx_next = {tx_reg[30:0], 1'b0};
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync_reg[0] <= 3'h0;
      sync_reg[1] <= 3'h7;
      sync_reg[2] <= 3'h0;
      lvl_reg     <= 3'h2;
      tx_reg      <= 32'h0000_0000;
      rx_reg      <= 32'h0000_0000;
      cnt_reg     <= 6'h00;
    end else begin
      sync_reg[0] <= {sync_reg[0][1:0], sclk};
      sync_reg[1] <= {sync_reg[1][1:0], cs_n};
      sync_reg[2] <= {sync_reg[2][1:0], mosi};
      lvl_reg     <= lvl_next;
      tx_reg      <= tx_next;
      rx_reg      <= rx_next;
      cnt_reg     <= cnt_next;
    end
  end

  // a frame of any other length is malformed
  assign frame_start = cs_fall;
  assign frame_done  = cs_rise && cnt_reg == 6'(FRAME_BITS); // [RULE17]
  assign frame_err   = cs_rise && cnt_reg != 6'(FRAME_BITS); // [RULE3]
  assign rx_word     = rx_reg;
  assign miso        = tx_reg[31];                           // [RULE17]
  assign miso_oe     = act;
endmodule

// ===== logic/fsr_fault_regs.sv
// fsr_fault_regs: fault flag register, interrupt pulse and soft reset.
// assumes monitor inputs are mclk-synchronous; spi, wake and int pins are not.
// Function
// [RULE1] fault read command; flags come back in the following frame
// [RULE2] bit 22 set by switch change or new flag; cleared by clear or read
// [RULE3] bit 10 set by malformed frame; clears on read without new error
// [RULE4] bit 9 hash mismatch; clears when gone and read
// [RULE5] bit 7 undervoltage; clears after recovery and read
// [RULE6] bit 6 overvoltage; clears after it ends and read
// [RULE7] bit 5 thermal warning; clears when cooled and read
// [RULE8] bit 4 thermal limit; clears when cooled and read
// [RULE9] bit 3 interrupt pin falling edge wake from low power
// [RULE10] bit 2 wake pin falling edge; clears on read
// [RULE11] bit 1 spi frame wake from low power; clears on read
// [RULE12] bit 0 power-on reset event; clears on read
// [RULE13] interrupt request command gives one 100 us low pulse
// [RULE14] request answer: header, summary, intflg, zeros; no intflg set
// [RULE15] reset command resets registers; answer is switch status; here it only clears the pulse timer and pulses soft_reset
// [RULE16] host sets rw bit for commands, clears it for fault read
// [RULE17] frame opens on chip select fall and has 32 clocks
// [RULE18] summary bit 23 is OR of flags and wetting faults; the fault reply sends 0 in bit 23
// [RULE19] any frame carrying intflg clears it; persisting faults don't re-fire
`timescale 1ns/1ps
module fsr_fault_regs
  import fsr_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            arst_n,
  input  wire logic            spi_sclk,
  input  wire logic            spi_cs_n,
  input  wire logic            spi_mosi,
  output logic                 spi_miso,
  output logic                 spi_miso_oe,
  input  wire logic            int_n_in,
  output logic                 int_n_out,
  output logic                 int_n_oe,
  input  wire logic            wake_n,
  input  wire logic [SW_W-1:0] switch_state,
  input  wire logic            wetting_fault,
  input  wire logic            supply_low_mon,
  input  wire logic            supply_high_mon,
  input  wire logic            thermal_warn_mon,
  input  wire logic            thermal_limit_mon,
  input  wire logic            hash_mismatch,
  input  wire logic            por_event,
  input  wire logic            low_power_state,
  output logic                 soft_reset
);
  // ==========================================================
  // spi target
  logic        frame_start, frame_done, frame_err, frame_end;
  logic [31:0] rx_word, tx_word;
  logic [6:0]  rx_addr;
  logic        rx_rw;

  fsr_spi_target u_spi (
    .mclk        (mclk),
    .arst_n      (arst_n),
    .sclk        (spi_sclk),
    .cs_n        (spi_cs_n),
    .mosi        (spi_mosi),
    .miso        (spi_miso),
    .miso_oe     (spi_miso_oe),
    .tx_word     (tx_word),
    .frame_start (frame_start),
    .frame_done  (frame_done),
    .frame_err   (frame_err),
    .rx_word     (rx_word)
  );

  assign frame_end = frame_done | frame_err;
  assign rx_addr   = rx_word[31:25];
  assign rx_rw     = rx_word[RW_BIT];

  // ==========================================================
  // pin sync for wake and interrupt pins
  logic [2:0] wk_sync_reg, it_sync_reg;
  logic       wk_lvl_reg, wk_lvl_next, it_lvl_reg, it_lvl_next;
  logic       wake_fall, int_fall;

  always_comb begin
    wk_lvl_next = (wk_sync_reg[1] == wk_sync_reg[2]) ? wk_sync_reg[2] : wk_lvl_reg;
    it_lvl_next = (it_sync_reg[1] == it_sync_reg[2]) ? it_sync_reg[2] : it_lvl_reg;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wk_sync_reg <= 3'h7;
      it_sync_reg <= 3'h7;
      wk_lvl_reg  <= 1'b1;
      it_lvl_reg  <= 1'b1;
    end else begin
      wk_sync_reg <= {wk_sync_reg[1:0], wake_n};
      it_sync_reg <= {it_sync_reg[1:0], int_n_in};
      wk_lvl_reg  <= wk_lvl_next;
      it_lvl_reg  <= it_lvl_next;
    end
  end

  assign wake_fall = wk_lvl_reg & ~wk_lvl_next;
  // own drive would look like an external edge, so ignore it then
  assign int_fall  = it_lvl_reg & ~it_lvl_next & ~int_n_oe;

  // ==========================================================
  // command decode
  logic      irq_fire, bad_addr;
  fsr_resp_t pend_reg, pend_next;

  assign irq_fire   = frame_done && rx_addr == ADDR_IRQ && rx_rw;      // [RULE13]
  assign soft_reset = frame_done && rx_addr == ADDR_RESET && rx_rw;    // [RULE15]
  assign bad_addr   = frame_done && rx_addr > ADDR_LAST;

  always_comb begin
    pend_next = pend_reg;
    if (frame_err) begin
      pend_next = RESP_SWITCH;
    end else if (frame_done) begin
      if (rx_addr == ADDR_FAULT && !rx_rw) begin
        pend_next = RESP_FAULT;                                         // [RULE1]
      end else if (irq_fire) begin
        pend_next = RESP_IRQ;                                           // [RULE14]
      end else begin
        pend_next = RESP_SWITCH;                                        // [RULE15]
      end
    end
  end

  // ==========================================================
  // fault flags: set wins over clear-on-read
  logic [FLAG_W-1:0] flags_reg, flags_next, snap_reg, snap_next;
  logic [FLAG_W-1:0] set_v, cause_v, clr_v;
  logic              snap_int_reg, snap_int_next;
  logic              intflg_reg, intflg_next, sum_prev_reg, summary;
  fsr_resp_t         snap_kind_reg, snap_kind_next;

  always_comb begin
    set_v              = '0;
    set_v[F_SPI_ERR]   = frame_err | bad_addr;                          // [RULE3]
    set_v[F_HASH]      = hash_mismatch;                                 // [RULE4]
    set_v[F_SUP_LOW]   = supply_low_mon;                                // [RULE5]
    set_v[F_SUP_HIGH]  = supply_high_mon;                               // [RULE6]
    set_v[F_TW]        = thermal_warn_mon;                              // [RULE7]
    set_v[F_TL]        = thermal_limit_mon;                             // [RULE8]
    set_v[F_INT_WAKE]  = low_power_state & int_fall;                    // [RULE9]
    set_v[F_PIN_WAKE]  = wake_fall;                                     // [RULE10]
    set_v[F_SPI_WAKE]  = low_power_state & frame_start;                 // [RULE11]
    set_v[F_POR]       = por_event;                                     // [RULE12]
    // level causes keep their flag up past the read
    cause_v            = '0;
    cause_v[F_HASH]    = hash_mismatch;
    cause_v[F_SUP_LOW] = supply_low_mon;
    cause_v[F_SUP_HIGH] = supply_high_mon;
    cause_v[F_TW]      = thermal_warn_mon;
    cause_v[F_TL]      = thermal_limit_mon;
    clr_v = (frame_end && snap_kind_reg == RESP_FAULT) ? (snap_reg & ~cause_v) : '0;
    flags_next = (flags_reg & ~clr_v) | set_v;                          // [RULE5]
    snap_next      = frame_start ? flags_reg : snap_reg;
    snap_int_next  = frame_start ? intflg_reg : snap_int_reg;
    snap_kind_next = frame_start ? pend_reg : snap_kind_reg;
  end

  // ==========================================================
  // summary and change flag
  logic [SW_W-1:0]   sw_prev_reg;
  logic              int_rise, int_clr;

  assign summary  = (|flags_reg) | wetting_fault;                       // [RULE18]
  // only a fresh flag or a switch change fires, so a persisting cause is quiet
  assign int_rise = (|(set_v & ~flags_reg)) | (switch_state != sw_prev_reg); // [RULE2]
  assign int_clr  = (frame_end & snap_int_reg) | (sum_prev_reg & ~summary);  // [RULE19]

  always_comb begin
    intflg_next = (intflg_reg & ~int_clr) | int_rise;                  // [RULE2]
  end

  // ==========================================================
  // response word for the next frame
  always_comb begin
    unique case (pend_reg)
      RESP_FAULT:  tx_word = {HDR_FAULT, 1'b0, intflg_reg, 11'h000, flags_reg}; // [RULE1]
      RESP_IRQ:    tx_word = {HDR_IRQ, summary, intflg_reg, 22'h00_0000};      // [RULE14]
      RESP_SWITCH: tx_word = {HDR_SWITCH, summary, intflg_reg, switch_state};  // [RULE15]
      default:     tx_word = {HDR_SWITCH, summary, intflg_reg, switch_state};
    endcase
  end

  // ==========================================================
  // interrupt pulse timer
  logic [PCNT_W-1:0] pcnt_reg, pcnt_next;
  logic              pulse_on;

  always_comb begin
    if (soft_reset) begin
      pcnt_next = '0;
    end else if (irq_fire) begin
      pcnt_next = PCNT_W'(INT_PULSE_CYC);                               // [RULE13]
    end else if (pcnt_reg != '0) begin
      pcnt_next = pcnt_reg - PCNT_W'(1);
    end else begin
      pcnt_next = pcnt_reg;
    end
  end

  assign pulse_on  = pcnt_reg != '0;
  // open drain: only ever pulls low
  assign int_n_out = 1'b0;
  assign int_n_oe  = pulse_on | intflg_reg;

  // ==========================================================
  // state registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flags_reg     <= FLAGS_RESET;
      snap_reg      <= '0;
      snap_int_reg  <= 1'b0;
      snap_kind_reg <= RESP_SWITCH;
      pend_reg      <= RESP_SWITCH;
      intflg_reg    <= INTFLG_RST;
      sum_prev_reg  <= 1'b0;
      sw_prev_reg   <= '0;
      pcnt_reg      <= '0;
    end else begin
      flags_reg     <= flags_next;
      snap_reg      <= snap_next;
      snap_int_reg  <= snap_int_next;
      snap_kind_reg <= snap_kind_next;
      pend_reg      <= pend_next;
      intflg_reg    <= intflg_next;
      sum_prev_reg  <= summary;
      sw_prev_reg   <= switch_state;
      pcnt_reg      <= pcnt_next;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  logic [PCNT_W-1:0] plen_reg;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) plen_reg <= '0;
    else plen_reg <= irq_fire ? '0 : (pulse_on ? plen_reg + PCNT_W'(1) : plen_reg);
  end

  sequence s_fault_cmd;
    frame_done && rx_addr == ADDR_FAULT && !rx_rw && !soft_reset;
  endsequence
  chk_pulse_len: assert property ($fell(pulse_on) |-> plen_reg == PCNT_W'(INT_PULSE_CYC)) // [RULE13]
    else $error("interrupt pulse length wrong");
  chk_pulse_drive: assert property (irq_fire |=> int_n_oe [*8]) // [RULE13]
    else $error("interrupt pulse not driven");
  chk_fault_reply: assert property (s_fault_cmd ##1 !frame_start [*1] |-> pend_reg == RESP_FAULT) // [RULE1]
    else $error("fault reply not queued");
  chk_err_flag: assert property (frame_err |=> flags_reg[F_SPI_ERR]) // [RULE3]
    else $error("frame error not flagged");
  chk_hash_hold: assert property (flags_reg[F_HASH] && hash_mismatch |=> flags_reg[F_HASH]) // [RULE4]
    else $error("hash flag lost while mismatch");
  chk_low_hold: assert property (flags_reg[F_SUP_LOW] && supply_low_mon |=> flags_reg[F_SUP_LOW]) // [RULE5]
    else $error("undervoltage flag lost");
  chk_high_set: assert property (supply_high_mon |=> flags_reg[F_SUP_HIGH]) // [RULE6]
    else $error("overvoltage flag not set");
  chk_therm_hold: assert property ((thermal_warn_mon || thermal_limit_mon)
    |=> flags_reg[F_TW] || flags_reg[F_TL]) // [RULE7]
    else $error("thermal flag not set");
  chk_wake_pin: assert property (wake_fall |=> flags_reg[F_PIN_WAKE]) // [RULE10]
    else $error("wake pin flag not set");
  chk_irq_reply: assert property (frame_start && pend_reg == RESP_IRQ
    |-> tx_word[21:0] == 22'h00_0000 && tx_word[31:24] == HDR_IRQ) // [RULE14]
    else $error("interrupt request reply wrong");
  chk_int_clear: assert property (frame_end && snap_int_reg && !int_rise && summary
    |=> !intflg_reg) // [RULE19]
    else $error("change flag not cleared by frame");
  chk_summary: assert property (flags_reg[F_POR] |-> tx_word[BIT_SUMMARY] || pend_reg == RESP_FAULT) // [RULE18]
    else $error("summary bit missing");
endmodule

// ===== bench/fsr_host_model.sv
// fsr_host_model: spi controller model standing in for the host.
// assumes the target samples mosi on sclk rise and shifts miso on fall.
`timescale 1ns/1ps
module fsr_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  // ==========================================
  // idle levels: sclk stands still between frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // ==========================================
  // one frame; half sets prompt or slow pace
  // miso taken late in the high phase, target answers through a pin sync
  task automatic xfer(input logic [31:0] tx, input int nbits, input int half,
                      output logic [31:0] rx);
    rx = 32'h0000_0000;
    #7;
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi = tx[31-i];
      #(i == 0 ? 2 * half : half);
      sclk = 1'b1;
      #(half - 5);
      rx = {rx[30:0], miso};
      #5;
      sclk = 1'b0;
    end
    #half;
    cs_n = 1'b1;
    mosi = ~mosi; // released line shows no stale value
    #(4 * half);
  endtask
endmodule

// ===== bench/fault_flag_and_command_regs_test.sv
// fault_flag_and_command_regs_test: self-checking bench for fsr_fault_regs.
// assumes the host model drives the spi pins; int wire has a pull-up.
`timescale 1ns/1ps
module fault_flag_and_command_regs_test;
  import fsr_pkg::*;
  logic            mclk, arst_n, sclk, cs_n, mosi, miso, miso_oe, miso_w;
  logic [SW_W-1:0] sw;
  logic [4:0]      mon;
  logic            wake_n, wet, por, lps, ext_low, int_w, int_oe, int_out, srst;
  logic [31:0]     r;
  int              err_count, checks_done, half, n;
  int              run = 0;
  int              last_run = 0;
  int              srst_cnt = 0;

  assign miso_w = miso_oe ? miso : ~miso;
  assign int_w  = ~(int_oe | ext_low);

  fsr_fault_regs fsr_fault_regs_inst (
    .mclk(mclk), .arst_n(arst_n), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso(miso), .spi_miso_oe(miso_oe), .int_n_in(int_w), .int_n_out(int_out),
    .int_n_oe(int_oe), .wake_n(wake_n), .switch_state(sw), .wetting_fault(wet),
    .supply_low_mon(mon[3]), .supply_high_mon(mon[2]), .thermal_warn_mon(mon[1]),
    .thermal_limit_mon(mon[0]), .hash_mismatch(mon[4]), .por_event(por),
    .low_power_state(lps), .soft_reset(srst));
  fsr_host_model fsr_host_model_inst (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_w));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ==========================================
  // low run length of the own interrupt drive (int_oe) and soft reset pulses
  always @(posedge mclk) begin
    if (int_oe) begin
      run <= run + 1;
    end else begin
      if (run > 0) last_run <= run;
      run <= 0;
    end
    if (srst) srst_cnt <= srst_cnt + 1;
  end
  // ==========================================
  // helpers
  function automatic logic [31:0] cmd(input logic [6:0] a, input logic rw);
    return {a, rw, 24'h00_0000};
  endfunction
  function automatic logic [31:0] swv(input logic s, input logic f);
    return {HDR_SWITCH, s, f, sw};
  endfunction
  function automatic logic [31:0] flt(input logic [10:0] fl);
    return {HDR_FAULT, 2'b00, 11'h000, fl};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic frame(input logic [31:0] tx);
    fsr_host_model_inst.xfer(tx, FRAME_BITS, half, r);
  endtask
  task automatic rd_fault;
    frame(cmd(ADDR_FAULT, 1'b0));
    frame(cmd(ADDR_SWITCH, 1'b0));
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_power_on;
    frame(cmd(ADDR_SWITCH, 1'b0));
    check(r, swv(1'b1, 1'b1), "first reply");
    frame(cmd(ADDR_FAULT, 1'b0));
    check(r, swv(1'b1, 1'b0), "change flag cleared");
    frame(cmd(ADDR_SWITCH, 1'b0));
    check(r, flt(11'h001), "power-on flag");
    rd_fault();
    check(r, flt(11'h000), "power-on flag cleared");
  endtask
  task automatic t_levels;
    @(posedge mclk);
    mon <= 5'h1F;
    tick(8);
    check({31'h0, int_oe}, 32'h1, "fault raises int");
    frame(cmd(ADDR_SWITCH, 1'b0));
    check(r, swv(1'b1, 1'b1), "fault reply");
    frame(cmd(ADDR_SWITCH, 1'b0));
    check(r, swv(1'b1, 1'b0), "no refire");
    check({31'h0, int_oe}, 32'h0, "int released");
    rd_fault();
    check(r, flt(11'h2F0), "level flags");
    @(posedge mclk);
    mon <= 5'h00;
    tick(4);
    rd_fault();
    check(r, flt(11'h2F0), "kept until read");
    rd_fault();
    check(r, flt(11'h000), "cleared");
  endtask
  task automatic t_events;
    @(posedge mclk);
    lps <= 1'b1;
    ext_low <= 1'b1;
    tick(10);
    ext_low <= 1'b0;
    wake_n <= 1'b0;
    por <= 1'b1;
    tick(1);
    por <= 1'b0;
    tick(10);
    wake_n <= 1'b1;
    frame(cmd(ADDR_SWITCH, 1'b0));
    check(r, swv(1'b1, 1'b1), "wake reply");
    @(posedge mclk);
    lps <= 1'b0;
    rd_fault();
    check(r, flt(11'h00F), "wake flags");
    rd_fault();
    check(r, flt(11'h000), "wake cleared");
  endtask
  task automatic t_spi_err;
    fsr_host_model_inst.xfer(cmd(ADDR_SWITCH, 1'b0), FRAME_BITS - 1, half, r);
    frame(cmd(ADDR_FAULT, 1'b0));
    check(r, swv(1'b1, 1'b1), "short frame refused");
    frame(cmd(7'h25, 1'b0));
    check(r, flt(11'h400), "error flag");
    rd_fault();
    check(r, flt(11'h400), "error during read kept");
    rd_fault();
    check(r, flt(11'h000), "error cleared");
  endtask
  task automatic t_irq;
    @(posedge mclk);
    wet <= 1'b1;
    frame(cmd(ADDR_IRQ, 1'b1));
    frame(cmd(ADDR_SWITCH, 1'b0));
    check(r, {HDR_IRQ, 2'b10, 22'h00_0000}, "request reply");
    tick(INT_PULSE_CYC + 40);
    check(last_run, INT_PULSE_CYC, "pulse length");
    check({31'h0, int_out}, 32'h0, "open drain pulls low");
  endtask
  task automatic t_reset;
    @(posedge mclk);
    sw <= 22'h2A_5A5A;
    tick(8);
    check({31'h0, int_oe}, 32'h1, "switch change int");
    n = srst_cnt;
    frame(cmd(ADDR_RESET, 1'b1));
    check(r, swv(1'b1, 1'b1), "switch change reply");
    check(srst_cnt - n, 1, "one reset pulse");
    frame(cmd(ADDR_SWITCH, 1'b0));
    check(r, swv(1'b1, 1'b0), "reset reply");
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    arst_n = 1'b0;
    sw = 22'h00_0000;
    mon = 5'h00;
    {wet, por, lps, ext_low} = 4'h0;
    wake_n = 1'b1;
    half = 100;
    err_count = 0;
    checks_done = 0;
    tick(2);
    check({31'h0, int_oe}, 32'h1, "change flag in reset");
    check({31'h0, miso_oe}, 32'h0, "miso released in reset");
    arst_n <= 1'b1;
    tick(6);
    t_power_on();
    t_levels();
    t_events();
    t_spi_err();
    t_irq();
    t_reset();
    summarize();
  end
  initial begin
    #1000000;
    err_count++;
    summarize();
  end
endmodule
